//--- common/boot_loader_pkg.sv
// Constants, register map and state types of the boot mode loader.
package boot_loader_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFF_ACCESS_EN   = 8'h00;
    localparam logic [7:0] OFF_FLASH_MODE1 = 8'h04;
    localparam logic [7:0] OFF_FLASH_MODE2 = 8'h08;
    localparam logic [7:0] OFF_ERASE_BLOCK = 8'h0c;
    localparam logic [7:0] OFF_FLASH_POWER = 8'h10;
    localparam logic [7:0] OFF_BOOT_STATUS = 8'h14;
    localparam logic [7:0] OFF_BAUD_DIV    = 8'h18;
    // Field positions, widths and reset values.
    localparam int         ACCESS_EN_BIT   = 7;
    localparam int         POWER_KEEP_BIT  = 7;
    localparam int         ERASE_BLOCK_W   = 5;
    localparam logic [7:0] REG_RESET       = 8'h00;
    // Loader RAM window.
    localparam logic [15:0] RAM_BASE       = 16'hf780;
    localparam logic [15:0] RAM_LAST       = 16'hfeef;
    localparam int          RAM_DEPTH      = int'(RAM_LAST) - int'(RAM_BASE) + 1;
    // Timing: one state is one clock cycle.
    localparam int          READY_STATES   = 100;
    localparam int          READY_CYCLES   = READY_STATES;
    localparam int          ZERO_CHAR_BITS = 9;
    localparam int          FRAME_BITS     = 10;
    // Handshake bytes.
    localparam logic [7:0]  BAUD_OK_BYTE   = 8'h00;
    localparam logic [7:0]  HANDSHAKE_BYTE = 8'h55;
    typedef enum logic [1:0] {
        MODE_USER  = 2'b00,
        MODE_BOOT  = 2'b01,
        MODE_PROG  = 2'b10,
        MODE_UNDEF = 2'b11
    } mode_e;
    typedef enum logic [3:0] {
        LD_IDLE     = 4'b0000,
        LD_SETTLE   = 4'b0001,
        LD_WAIT_LOW = 4'b0010,
        LD_MEASURE  = 4'b0011,
        LD_SEND_ACK = 4'b0100,
        LD_WAIT_55  = 4'b0101,
        LD_SIZE_HI  = 4'b0110,
        LD_SIZE_LO  = 4'b0111,
        LD_LOAD     = 4'b1000,
        LD_ERASE    = 4'b1001,
        LD_BRANCH   = 4'b1010,
        LD_RUN      = 4'b1011
    } loader_e;
endpackage

//--- hdl/boot_loader.sv
// Boot mode entry, bit-rate matching loader and flash control register gate.
// How it works
// - Access bit zero blocks flash register access.
// - Bit gates mode, erase block, power registers.
// - Low seven access bits read zero.
// - Pins at reset end pick the mode.
// - Load program, erase flash, then branch.
// - Link is 8 bits, one stop, no parity.
// - Time zero characters, match host bit rate.
// - Ready to measure 100 states after reset.
// - Send zero byte, host answers 0x55.
// - Program lands between 0xF780 and 0xFEEF.
// - Branch clears enables, keeps divisor, tx high.
// - Watchdog overflow ends boot mode.
// - Flash unreadable while program or erase runs.
// - Watchdog runs after reset release.
//
// The APB interface to the registers and the address map are this design's own decisions.
module boot_loader #(
    parameter int DIV_W  = 16,
    parameter int MEAS_W = 20
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        testPin,
    input  wire logic        boot_select_pin,
    input  wire logic        boot_qualify_pin,
    input  wire logic        programmer_select_pin0,
    input  wire logic        programmer_select_pin1,
    input  wire logic        programmer_select_pin2,
    input  wire logic        rxPin,
    output logic             txPinOut,
    output logic             txPinOe,
    input  wire logic        wdtOverflow,
    input  wire logic        flashBusy,
    input  wire logic        eraseDone,
    input  wire logic [7:0]  flashStatus,
    input  wire logic [15:0] ramRdAddr,
    output logic      [7:0]  ramRdData,
    output logic      [1:0]  bootMode,
    output logic      [7:0]  flashMode1,
    output logic      [4:0]  eraseBlock,
    output logic             flashPowerKeep,
    output logic             eraseAllReq,
    output logic             programStart,
    output logic             flashReadBlock,
    output logic             wdtRun
);
    logic [7:0]        ram [boot_loader_pkg::RAM_DEPTH];
    logic [5:0]        pinMeta_r, pinSync_r;
    logic              rxMeta_r, rxSync_r;
    logic [1:0]        catchCnt_r;
    logic              ctrl_reg_access_en_r;
    boot_loader_pkg::loader_e state_r;
    logic [6:0]        settleCnt_r;
    logic [MEAS_W-1:0] lowCnt_r;
    logic [DIV_W-1:0]  baud_divisor_r;
    logic              receive_en_r, transmit_en_r;
    logic [DIV_W-1:0]  rxCnt_r, txCnt_r;
    logic [3:0]        rxBit_r, txBit_r;
    logic              rxBusy_r, rxValid_r, txBusy_r, txStart_r;
    logic [7:0]        rxShift_r;
    logic [9:0]        txShift_r;
    logic [15:0]       loadLen_r, loadIdx_r;
    logic              apbWrite, apbSetup;

    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pready && pwrite;

    // Mode pins and receive line pass two flip-flops before use.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinMeta_r <= 6'h00;
            pinSync_r <= 6'h00;
            rxMeta_r  <= 1'b1;
            rxSync_r  <= 1'b1;
        end else begin
            pinMeta_r <= {testPin, boot_select_pin, boot_qualify_pin,
                          programmer_select_pin0, programmer_select_pin1,
                          programmer_select_pin2};
            pinSync_r <= pinMeta_r;
            rxMeta_r  <= rxPin;
            rxSync_r  <= rxMeta_r;
        end
    end

    // Mode is caught once the synchronised pins are valid after reset or overflow.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            catchCnt_r <= 2'h0;
            bootMode   <= boot_loader_pkg::MODE_UNDEF;
        end else if (wdtOverflow) begin
            catchCnt_r <= 2'h0;
            bootMode   <= boot_loader_pkg::MODE_UNDEF;
        end else if (catchCnt_r != 2'h3) begin
            catchCnt_r <= catchCnt_r + 2'h1;
            if (catchCnt_r == 2'h2) begin
                if (!pinSync_r[5] && pinSync_r[4]) begin
                    bootMode <= boot_loader_pkg::MODE_USER;
                end else if (!pinSync_r[5] && pinSync_r[3]) begin
                    bootMode <= boot_loader_pkg::MODE_BOOT;
                end else if (pinSync_r[5] && pinSync_r[2:0] == 3'h0) begin
                    bootMode <= boot_loader_pkg::MODE_PROG;
                end else begin
                    bootMode <= boot_loader_pkg::MODE_UNDEF;
                end
            end
        end
    end

    // Loader sequence: settle, measure, acknowledge, load, erase, branch.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r        <= boot_loader_pkg::LD_IDLE;
            settleCnt_r    <= 7'h00;
            lowCnt_r       <= '0;
            baud_divisor_r <= '0;
            receive_en_r   <= 1'b0;
            transmit_en_r  <= 1'b0;
            txStart_r      <= 1'b0;
            loadLen_r      <= 16'h0000;
            loadIdx_r      <= 16'h0000;
            eraseAllReq    <= 1'b0;
            programStart   <= 1'b0;
        end else if (wdtOverflow) begin
            state_r       <= boot_loader_pkg::LD_IDLE;
            receive_en_r  <= 1'b0;
            transmit_en_r <= 1'b0;
            txStart_r     <= 1'b0;
            eraseAllReq   <= 1'b0;
            programStart  <= 1'b0;
        end else begin
            txStart_r <= 1'b0;
            unique case (state_r)
                boot_loader_pkg::LD_IDLE: begin
                    settleCnt_r <= 7'h00;
                    if (bootMode == boot_loader_pkg::MODE_BOOT) begin
                        state_r <= boot_loader_pkg::LD_SETTLE;
                    end
                end
                boot_loader_pkg::LD_SETTLE: begin
                    settleCnt_r <= settleCnt_r + 7'h01;
                    if (settleCnt_r == 7'(boot_loader_pkg::READY_CYCLES - 1)) begin
                        state_r <= boot_loader_pkg::LD_WAIT_LOW;
                    end
                end
                boot_loader_pkg::LD_WAIT_LOW: begin
                    lowCnt_r <= '0;
                    if (!rxSync_r) begin
                        state_r <= boot_loader_pkg::LD_MEASURE;
                    end
                end
                boot_loader_pkg::LD_MEASURE: begin
                    if (!rxSync_r) begin
                        lowCnt_r <= lowCnt_r + 1'b1;
                    end else begin
                        // Low period spans start bit and eight zero bits.
                        baud_divisor_r <= DIV_W'(lowCnt_r
                                          / MEAS_W'(boot_loader_pkg::ZERO_CHAR_BITS));
                        transmit_en_r  <= 1'b1;
                        state_r        <= boot_loader_pkg::LD_SEND_ACK;
                    end
                end
                boot_loader_pkg::LD_SEND_ACK: begin
                    if (!txBusy_r && !txStart_r) begin
                        txStart_r    <= 1'b1;
                        receive_en_r <= 1'b1;
                        state_r      <= boot_loader_pkg::LD_WAIT_55;
                    end
                end
                boot_loader_pkg::LD_WAIT_55: begin
                    if (rxValid_r && rxShift_r == boot_loader_pkg::HANDSHAKE_BYTE) begin
                        state_r <= boot_loader_pkg::LD_SIZE_HI;
                    end
                end
                boot_loader_pkg::LD_SIZE_HI: begin
                    if (rxValid_r) begin
                        loadLen_r[15:8] <= rxShift_r;
                        state_r         <= boot_loader_pkg::LD_SIZE_LO;
                    end
                end
                boot_loader_pkg::LD_SIZE_LO: begin
                    if (rxValid_r) begin
                        loadLen_r[7:0] <= rxShift_r;
                        loadIdx_r      <= 16'h0000;
                        state_r        <= boot_loader_pkg::LD_LOAD;
                    end
                end
                boot_loader_pkg::LD_LOAD: begin
                    if (loadIdx_r == loadLen_r
                            || loadIdx_r == 16'(boot_loader_pkg::RAM_DEPTH)) begin
                        eraseAllReq <= 1'b1;
                        state_r     <= boot_loader_pkg::LD_ERASE;
                    end else if (rxValid_r) begin
                        loadIdx_r <= loadIdx_r + 16'h0001;
                    end
                end
                boot_loader_pkg::LD_ERASE: begin
                    if (eraseDone) begin
                        eraseAllReq <= 1'b0;
                        state_r     <= boot_loader_pkg::LD_BRANCH;
                    end
                end
                boot_loader_pkg::LD_BRANCH: begin
                    if (!txBusy_r) begin
                        receive_en_r  <= 1'b0;
                        transmit_en_r <= 1'b0;
                        programStart  <= 1'b1;
                        state_r       <= boot_loader_pkg::LD_RUN;
                    end
                end
                boot_loader_pkg::LD_RUN: begin
                    programStart <= 1'b1;
                end
                default: begin
                    state_r <= boot_loader_pkg::LD_IDLE;
                end
            endcase
        end
    end

    // Received program bytes fill the loader RAM window; a read port faces the core.
    always_ff @(posedge clk) begin
        if (state_r == boot_loader_pkg::LD_LOAD && rxValid_r
                && loadIdx_r < 16'(boot_loader_pkg::RAM_DEPTH)) begin
            ram[loadIdx_r[10:0]] <= rxShift_r;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ramRdData <= 8'h00;
        end else if (ramRdAddr >= boot_loader_pkg::RAM_BASE
                && ramRdAddr <= boot_loader_pkg::RAM_LAST) begin
            ramRdData <= ram[11'(ramRdAddr - boot_loader_pkg::RAM_BASE)];
        end else begin
            ramRdData <= 8'h00;
        end
    end

    // Receiver: start bit, eight data bits, one stop bit, no parity, sampled mid-bit.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxBusy_r  <= 1'b0;
            rxValid_r <= 1'b0;
            rxCnt_r   <= '0;
            rxBit_r   <= 4'h0;
            rxShift_r <= 8'h00;
        end else begin
            rxValid_r <= 1'b0;
            if (!receive_en_r) begin
                rxBusy_r <= 1'b0;
            end else if (!rxBusy_r) begin
                if (!rxSync_r) begin
                    rxBusy_r <= 1'b1;
                    rxBit_r  <= 4'h0;
                    rxCnt_r  <= baud_divisor_r >> 1;
                end
            end else if (rxCnt_r != '0) begin
                rxCnt_r <= rxCnt_r - 1'b1;
            end else begin
                rxCnt_r <= baud_divisor_r;
                rxBit_r <= rxBit_r + 4'h1;
                if (rxBit_r == 4'h0 && rxSync_r) begin
                    rxBusy_r <= 1'b0;
                end else if (rxBit_r == 4'h9) begin
                    rxBusy_r  <= 1'b0;
                    rxValid_r <= rxSync_r;
                end else if (rxBit_r != 4'h0) begin
                    rxShift_r <= {rxSync_r, rxShift_r[7:1]};
                end
            end
        end
    end

    // Transmitter: frame is start, eight data bits, stop; the line idles high.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txBusy_r  <= 1'b0;
            txCnt_r   <= '0;
            txBit_r   <= 4'h0;
            txShift_r <= 10'h3ff;
            txPinOut  <= 1'b1;
            txPinOe   <= 1'b0;
        end else begin
            if (transmit_en_r) begin
                txPinOe <= 1'b1;
            end
            if (txStart_r) begin
                txBusy_r  <= 1'b1;
                txShift_r <= {1'b1, boot_loader_pkg::BAUD_OK_BYTE, 1'b0};
                txBit_r   <= 4'h0;
                txCnt_r   <= '0;
            end else if (txBusy_r) begin
                if (txCnt_r != '0) begin
                    txCnt_r <= txCnt_r - 1'b1;
                end else if (txBit_r == 4'(boot_loader_pkg::FRAME_BITS)) begin
                    txBusy_r <= 1'b0;
                end else begin
                    txPinOut  <= txShift_r[0];
                    txShift_r <= {1'b1, txShift_r[9:1]};
                    txBit_r   <= txBit_r + 4'h1;
                    txCnt_r   <= baud_divisor_r;
                end
            end else begin
                txPinOut <= 1'b1;
            end
        end
    end

    // Flash control registers, reachable only while the access bit is set.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg_access_en_r <= 1'b0;
            flashMode1           <= boot_loader_pkg::REG_RESET;
            eraseBlock           <= 5'h00;
            flashPowerKeep       <= 1'b0;
        end else if (apbWrite) begin
            if (paddr == boot_loader_pkg::OFF_ACCESS_EN) begin
                ctrl_reg_access_en_r <= pwdata[boot_loader_pkg::ACCESS_EN_BIT];
            end
            if (ctrl_reg_access_en_r) begin
                if (paddr == boot_loader_pkg::OFF_FLASH_MODE1) begin
                    flashMode1 <= pwdata[7:0];
                end
                if (paddr == boot_loader_pkg::OFF_ERASE_BLOCK) begin
                    eraseBlock <= pwdata[boot_loader_pkg::ERASE_BLOCK_W-1:0];
                end
                if (paddr == boot_loader_pkg::OFF_FLASH_POWER) begin
                    flashPowerKeep <= pwdata[boot_loader_pkg::POWER_KEEP_BIT];
                end
            end
        end
    end

    // Read data is prepared in the setup cycle and answered in the first access cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbSetup;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (apbSetup) begin
                unique case (paddr)
                    boot_loader_pkg::OFF_ACCESS_EN:
                        prdata[boot_loader_pkg::ACCESS_EN_BIT] <= ctrl_reg_access_en_r;
                    boot_loader_pkg::OFF_FLASH_MODE1:
                        prdata[7:0] <= ctrl_reg_access_en_r ? flashMode1 : 8'h00;
                    boot_loader_pkg::OFF_FLASH_MODE2:
                        prdata[7:0] <= ctrl_reg_access_en_r ? flashStatus : 8'h00;
                    boot_loader_pkg::OFF_ERASE_BLOCK:
                        prdata[4:0] <= ctrl_reg_access_en_r ? eraseBlock : 5'h00;
                    boot_loader_pkg::OFF_FLASH_POWER:
                        prdata[7] <= ctrl_reg_access_en_r && flashPowerKeep;
                    boot_loader_pkg::OFF_BOOT_STATUS:
                        prdata[7:0] <= {transmit_en_r, receive_en_r, state_r, bootMode};
                    boot_loader_pkg::OFF_BAUD_DIV:
                        prdata[DIV_W-1:0] <= baud_divisor_r;
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Flash array is blocked while busy; the watchdog runs from reset release.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flashReadBlock <= 1'b0;
            wdtRun         <= 1'b0;
        end else begin
            flashReadBlock <= flashBusy;
            wdtRun         <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence blockedWrite;
        apbWrite && !ctrl_reg_access_en_r && paddr == boot_loader_pkg::OFF_FLASH_MODE1;
    endsequence
    a_gate_blocks_write: assert property (blockedWrite |=> $stable(flashMode1))
        else $error("Flash mode register changed while access is blocked.");
    a_reserved_read_zero: assert property (psel && penable && pready && !pwrite
        && paddr == boot_loader_pkg::OFF_ACCESS_EN |-> prdata[6:0] == 7'h00)
        else $error("Reserved access bits did not read zero.");
    a_mode_boot_pick: assert property (catchCnt_r == 2'h2 && !pinSync_r[5] && !pinSync_r[4]
        && pinSync_r[3] && !wdtOverflow |=> bootMode == boot_loader_pkg::MODE_BOOT)
        else $error("Boot mode not selected from pin levels.");
    a_settle_length: assert property ($rose(state_r == boot_loader_pkg::LD_WAIT_LOW)
        |-> $past(settleCnt_r) == 7'(boot_loader_pkg::READY_CYCLES - 1))
        else $error("Measurement became ready at the wrong time.");
    a_divisor_ninth: assert property (state_r == boot_loader_pkg::LD_MEASURE && rxSync_r
        && !wdtOverflow |=> baud_divisor_r == DIV_W'($past(lowCnt_r) / 9))
        else $error("Divisor is not a ninth of the low period.");
    // The frame is loaded, then its start bit goes out with the zero byte queued behind it.
    sequence ackSent;
        txStart_r ##1 (txBusy_r && txBit_r == 4'h0);
    endsequence
    a_ack_zero_byte: assert property (ackSent |=> !txPinOut
        && txShift_r[7:0] == boot_loader_pkg::BAUD_OK_BYTE)
        else $error("Rate acknowledge byte was not zero.");
    a_branch_after_erase: assert property ($rose(programStart) |->
        $past(state_r) == boot_loader_pkg::LD_BRANCH && !eraseAllReq)
        else $error("Branch taken without finished erase.");
    a_branch_cleanup: assert property ($rose(programStart) |-> ##1 (!receive_en_r
        && !transmit_en_r && txPinOe && baud_divisor_r == $past(baud_divisor_r, 2)))
        else $error("Serial port not left idle at branch.");
    a_wdt_exit: assert property (wdtOverflow |=> state_r == boot_loader_pkg::LD_IDLE
        && bootMode == boot_loader_pkg::MODE_UNDEF)
        else $error("Watchdog overflow did not end boot mode.");
endmodule

//--- verification/boot_host.sv
// Host model: zero stream for bit-rate matching, acknowledge and download.
module boot_host (
    input  wire logic clk,
    input  wire logic go,
    input  wire logic txLine,
    output logic      rxLine,
    output logic [7:0] ackByte
);
    timeunit 1ns;
    timeprecision 1ps;
    // Host bit time in clocks; a fast rate keeps the run short and the match scales.
    localparam int BIT = 36;
    logic gotAck = 1'b0;
    // Handshake, a two-byte size and a small program that stays inside the load window.
    logic [7:0] msg [5] = '{8'h55, 8'h00, 8'h02, 8'ha5, 8'h3c};
    // Sends one frame: start bit, data LSB first, one stop bit, no parity.
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxLine <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask
    // Streams zeros until the device answers, then sends 0x55, size and code.
    initial begin
        rxLine = 1'b1;
        wait (go === 1'b1);
        while (!gotAck) sendByte(8'h00);
        if (ackByte === 8'h00) begin
            for (int i = 0; i < 5; i++) sendByte(msg[i]);
        end
    end
    // Samples the device frame near mid-bit, stepping BIT + 1 clocks per bit, one more than the device bit time.
    initial begin
        ackByte = 8'hff;
        wait (go === 1'b1);
        while (txLine !== 1'b0) @(posedge clk);
        repeat ((BIT + 1) / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT + 1) @(posedge clk);
            ackByte[i] = txLine;
        end
        gotAck = 1'b1;
    end
endmodule

//--- verification/boot_loader_test.sv
// Self-checking bench of the boot loader and its register gate.
module boot_loader_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, flashStatus = 8'h80, ackByte, ramRdData, flashMode1;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, se, rxPin, txPinOut, txPinOe, flashPowerKeep, eraseAllReq;
    logic programStart, flashReadBlock, wdtRun, go = 1'b0, wdtOverflow = 1'b0;
    logic flashBusy = 1'b0, eraseDone = 1'b0;
    logic [5:0] strap = 6'h08;
    logic [15:0] ramRdAddr = 16'h0;
    logic [1:0] bootMode;
    logic [4:0] eraseBlock;
    int cyc = 0, n_errors = 0, compares = 0;
    boot_loader boot_loader_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .testPin(strap[5]), .boot_select_pin(strap[4]),
        .boot_qualify_pin(strap[3]), .programmer_select_pin0(strap[2]),
        .programmer_select_pin1(strap[1]), .programmer_select_pin2(strap[0]),
        .rxPin(rxPin), .txPinOut(txPinOut), .txPinOe(txPinOe), .wdtOverflow(wdtOverflow),
        .flashBusy(flashBusy), .eraseDone(eraseDone), .flashStatus(flashStatus),
        .ramRdAddr(ramRdAddr), .ramRdData(ramRdData), .bootMode(bootMode),
        .flashMode1(flashMode1), .eraseBlock(eraseBlock), .flashPowerKeep(flashPowerKeep),
        .eraseAllReq(eraseAllReq), .programStart(programStart),
        .flashReadBlock(flashReadBlock), .wdtRun(wdtRun));
    boot_host boot_host_inst (.clk(clk), .go(go), .txLine(txPinOut), .rxLine(rxPin),
        .ackByte(ackByte));
    // Clock and cycle ceiling that cuts a hang short.
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reset low for 30 cycles, new straps set after 20 and held stable well before release.
    task automatic restart(input logic [5:0] s);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (20) @(posedge clk);
        strap <= s;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic testModes();
        logic [5:0] s [4] = '{6'h10, 6'h08, 6'h20, 6'h00};
        for (int i = 0; i < 4; i++) begin
            restart(s[i]);
            chk("bootMode", bootMode, i);
        end
        chk("wdtRun", wdtRun, 1'b1);
        $display("test modes done");
    endtask
    task automatic testRegs();
        apb(1'b1, 8'h04, 32'h5a);
        apb(1'b0, 8'h04, 32'h0);
        chk("mode1 locked", q, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk("status locked", q, 32'h0);
        apb(1'b1, 8'h00, 32'hff);
        apb(1'b0, 8'h00, 32'h0);
        chk("access", q, 32'h80);
        apb(1'b1, 8'h04, 32'h5a);
        apb(1'b1, 8'h0c, 32'h04);
        apb(1'b1, 8'h10, 32'h80);
        apb(1'b0, 8'h08, 32'h0);
        chk("status", q, 32'h80);
        chk("mode1", flashMode1, 8'h5a);
        chk("erase", eraseBlock, 5'h04);
        chk("power", flashPowerKeep, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", se, 1'b1);
        flashBusy <= 1'b1;
        repeat (2) @(posedge clk);
        chk("readBlock", flashReadBlock, 1'b1);
        flashBusy <= 1'b0;
        repeat (2) @(posedge clk);
        chk("readFree", flashReadBlock, 1'b0);
        $display("test registers done");
    endtask
    task automatic testBoot();
        restart(6'h08);
        repeat (120) @(posedge clk);
        go <= 1'b1;
        while (eraseAllReq !== 1'b1) @(posedge clk);
        chk("ack", ackByte, 8'h00);
        chk("early start", programStart, 1'b0);
        eraseDone <= 1'b1;
        @(posedge clk);
        eraseDone <= 1'b0;
        while (programStart !== 1'b1) @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            ramRdAddr <= boot_loader_pkg::RAM_BASE + 16'(i);
            repeat (2) @(posedge clk);
            chk("ram", ramRdData, i == 0 ? 8'ha5 : 8'h3c);
        end
        apb(1'b0, 8'h14, 32'h0);
        chk("enables", q[7:6], 2'b00);
        chk("tx", {txPinOut, txPinOe}, 2'b11);
        apb(1'b0, 8'h18, 32'h0);
        chk("divisor", q >= 35 && q <= 37, 1'b1);
        $display("test boot done");
    endtask
    task automatic testWatchdog();
        wdtOverflow <= 1'b1;
        @(posedge clk);
        wdtOverflow <= 1'b0;
        repeat (3) @(posedge clk);
        chk("abort", programStart, 1'b0);
        $display("test watchdog done");
    endtask
    task automatic summarize();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        testModes();
        testRegs();
        testBoot();
        testWatchdog();
        summarize();
    end
endmodule
